/* design/uart_mode_defs.vh */
// register offsets, field positions, reset values and depths for the channel mode logic
`ifndef UART_MODE_DEFS_VH
`define UART_MODE_DEFS_VH

// ============================================================
// host register offsets (8-byte window)
`define OFF_DATA        3'h0
`define OFF_IER         3'h1
`define OFF_FIFO_CTL    3'h2
`define OFF_LINE_CTL    3'h3
`define OFF_MODEM_CTL   3'h4
`define OFF_ICR_DATA    3'h5
`define OFF_MODEM_STAT  3'h6
`define OFF_ICR_INDEX   3'h7

// ============================================================
// indexed control set entries
`define IDX_ADD_CTL     8'h00
`define IDX_PRESCALER   8'h01
`define IDX_CLOCK_SEL   8'h02
`define IDX_SAMPLE      8'h03
`define IDX_RX_TRIG     8'h04
`define IDX_TX_TRIG     8'h05
`define IDX_FLOW_LOW    8'h06
`define IDX_FLOW_HIGH   8'h07
`define IDX_NINE_BIT    8'h08

// ============================================================
// field positions
`define FC_ENABLE       0
`define FC_RX_FLUSH     1
`define FC_TX_FLUSH     2
`define FC_DEEP         5
`define LC_DLAB         7
`define EF_ENHANCED     4
`define EF_AUTO_RTS     6
`define AC_TRIG         5
`define AC_ICR          6
`define AC_STAT         7
`define MC_DTR          0
`define MC_AUTO_FLOW    5
`define IE_SLEEP        4
`define CK_RX_EXT       0
`define CK_TX_EXT       4
`define CK_TX_DTR       5
`define NB_ENABLE       0
`define NB_TX_BIT8      1

// ============================================================
// reset values and constants
`define ENH_KEY         8'hbf
`define RST_PRESCALER   8'h20
`define RST_SAMPLE      8'h00
`define RST_DIVISOR     16'h0001
`define RST_BYTE        8'h00
`define DEPTH_BYTE      8'h01
`define DEPTH_STD       8'h10
`define DEPTH_DEEP      8'h80
`define PRESC_UNIT      9'h008
`define SAMPLE_MIN      4'h4
`define SAMPLE_DEFAULT  5'h10

`endif

/* design/mode_fifo.v */
// fifo whose effective depth is chosen at run time, with registered head data
`timescale 1ns/1ps
`include "uart_mode_defs.vh"

module mode_fifo #(
  parameter WIDTH = 9,
  parameter AW    = 7
) (
  input  wire             sys_clk,
  input  wire             rstn,
  input  wire [7:0]       depth_lim,
  input  wire             flush,
  input  wire             push,
  input  wire [WIDTH-1:0] push_data,
  input  wire             pop,
  output reg  [WIDTH-1:0] head_q,
  output reg              head_valid_q,
  output wire             full,
  output reg  [7:0]       level_q
);
  // ============================================================
  // storage
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0]    wptr_q;
  reg [AW-1:0]    rptr_q;
  wire            do_push;
  wire            do_pop;

  // limit compared against the live depth, so a depth change acts on the next access
  assign full    = (level_q >= depth_lim);
  assign do_push = push & ~full & ~flush;
  assign do_pop  = pop & head_valid_q & ~flush;

  always @(posedge sys_clk) begin
    if (do_push) begin
      mem[wptr_q] <= push_data;
    end
    head_q <= mem[rptr_q];
  end

  // ============================================================
  // pointers and level
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wptr_q       <= {AW{1'b0}};
      rptr_q       <= {AW{1'b0}};
      level_q      <= 8'h00;
      head_valid_q <= 1'b0;
    end else if (flush) begin
      wptr_q       <= {AW{1'b0}};
      rptr_q       <= {AW{1'b0}};
      level_q      <= 8'h00;
      head_valid_q <= 1'b0;
    end else begin
      if (do_push) begin
        wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rptr_q <= rptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_push & ~do_pop) begin
        level_q <= level_q + 8'h01;
      end else if (do_pop & ~do_push) begin
        level_q <= level_q - 8'h01;
      end
      // head becomes valid one edge after the read port has caught up
      head_valid_q <= (level_q != 8'h00) & ~do_pop;
    end
  end
endmodule // mode_fifo

/* design/baud_clock_gen.v */
// fractional prescaler, divisor, external clock pick-up and oversampling counter
`timescale 1ns/1ps
`include "uart_mode_defs.vh"

module baud_clock_gen (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire [7:0]  prescaler_ratio,
  input  wire [15:0] divisor,
  input  wire [7:0]  sample_clock_ratio,
  input  wire [7:0]  clock_select,
  input  wire        ring_indicator_n,
  input  wire        dsr_n,
  input  wire        dtr_i,
  output wire        rx_sample_tick,
  output reg         tx_bit_tick,
  output wire [4:0]  sample_ratio
);
  // ============================================================
  // pin synchronisers: stage 1 feeds stage 2 only
  reg  [2:0] pin_s1_q;
  reg  [2:0] pin_s2_q;
  reg  [2:0] pin_d3_q;
  wire [2:0] pin_rise;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
      pin_d3_q <= 3'h7;
    end else begin
      pin_s1_q <= {dtr_i, dsr_n, ring_indicator_n};
      pin_s2_q <= pin_s1_q;
      pin_d3_q <= pin_s2_q;
    end
  end
  assign pin_rise = pin_s2_q & ~pin_d3_q;

  // ============================================================
  // M+N/8 prescaler: the register value is the ratio in eighths
  reg  [8:0] frac_q;
  reg        presc_tick_q;
  wire [8:0] ratio8 = (prescaler_ratio < 8'h08) ? `PRESC_UNIT : {1'b0, prescaler_ratio};
  wire [8:0] frac_sum = frac_q + `PRESC_UNIT;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frac_q       <= 9'h000;
      presc_tick_q <= 1'b0;
    end else if (frac_sum >= ratio8) begin
      frac_q       <= frac_sum - ratio8;
      presc_tick_q <= 1'b1;
    end else begin
      frac_q       <= frac_sum;
      presc_tick_q <= 1'b0;
    end
  end

  // ============================================================
  // divisor latch counter, zero treated as one
  reg  [15:0] div_q;
  reg         samp_int_q;
  wire [15:0] div_max = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_q      <= 16'h0000;
      samp_int_q <= 1'b0;
    end else begin
      samp_int_q <= 1'b0;
      if (presc_tick_q) begin
        if (div_q >= div_max) begin
          div_q      <= 16'h0000;
          samp_int_q <= 1'b1;
        end else begin
          div_q <= div_q + 16'h0001;
        end
      end
    end
  end

  // ============================================================
  // source pick and oversampling
  wire tx_ext_edge = clock_select[`CK_TX_DTR] ? pin_rise[2] : pin_rise[0];
  wire tx_samp = clock_select[`CK_TX_EXT] ? tx_ext_edge : samp_int_q;
  assign rx_sample_tick = clock_select[`CK_RX_EXT] ? pin_rise[1] : samp_int_q;

  // values below four fall back to sixteen cycles per bit
  assign sample_ratio = (sample_clock_ratio[3:0] < `SAMPLE_MIN) ? `SAMPLE_DEFAULT :
                        {1'b0, sample_clock_ratio[3:0]};

  reg [4:0] bit_cnt_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q   <= 5'h00;
      tx_bit_tick <= 1'b0;
    end else begin
      tx_bit_tick <= 1'b0;
      if (tx_samp) begin
        if (bit_cnt_q >= sample_ratio - 5'h01) begin
          bit_cnt_q   <= 5'h00;
          tx_bit_tick <= 1'b1;
        end else begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
      end
    end
  end
endmodule // baud_clock_gen

/* design/uart_mode_ctrl.v */
// channel mode selection, fifo depth, extended feature gating and host registers
// Contract
// - reset clears fifo enable: byte mode
// - fifo enable low ignores other mode inputs
// - enable, no enhanced, deep clear, pin high: 16
// - enable, no enhanced, pin low: 128
// - guarded deep bit enlarges 16 to 128
// - deep bit writable only with divisor access set
// - legacy deep features only outside enhanced mode
// - enhanced with enable gives 128 always
// - trigger bit swaps fifo fields for threshold registers
// - flow status readable for both transmitters
// - receive and transmit fill levels readable
// - prescaler divides by M plus N/8
// - prescaler resets to divide by four
// - clock select picks external transmit/receive clocks
// - sample ratio resets zero meaning sixteen
// - ratio 1-3 gives sixteen, 4-15 exact
// - nine data bits supported in extended mode
// - indexed set readable when control bit six set
`timescale 1ns/1ps
`include "uart_mode_defs.vh"

module uart_mode_ctrl (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire [2:0] host_addr,
  input  wire [7:0] host_wdata,
  input  wire       host_wr,
  input  wire       host_rd,
  output reg  [7:0] host_rdata,
  input  wire       deep_fifo_select_n,
  input  wire       ring_indicator_n,
  input  wire       dsr_n,
  input  wire       dtr_i,
  output wire       dtr_o,
  output wire       dtr_oe,
  output wire [8:0] tx_data,
  output wire       tx_valid,
  input  wire       tx_take,
  input  wire [8:0] rx_data,
  input  wire       rx_push,
  input  wire       remote_xoff,
  output wire [7:0] fifo_depth,
  output wire       rx_trigger_hit,
  output wire       tx_trigger_hit,
  output wire       remote_stop,
  output wire       auto_rts_cts,
  output wire       sleep_enable,
  output wire       nine_bit_mode,
  output wire       tx_bit_tick,
  output wire       rx_sample_tick,
  output wire [4:0] sample_ratio
);
  // ============================================================
  // host visible registers
  reg [7:0]  fifo_control_q;
  reg [7:0]  line_control_q;
  reg [7:0]  enhanced_features_q;
  reg [7:0]  ier_q;
  reg [7:0]  modem_ctl_q;
  reg [7:0]  icr_index_q;
  reg [15:0] divisor_q;
  reg [7:0]  additional_control_q;
  reg [7:0]  prescaler_ratio_q;
  reg [7:0]  clock_select_q;
  reg [7:0]  sample_clock_ratio_q;
  reg [7:0]  rx_interrupt_threshold_q;
  reg [7:0]  tx_threshold_q;
  reg [7:0]  flow_low_threshold_q;
  reg [7:0]  flow_high_threshold_q;
  reg [7:0]  nine_bit_q;
  reg        overrun_q;
  reg        enh_key_q;
  reg        remote_stop_q;

  // ============================================================
  // deep fifo select pin synchroniser
  reg sel_s1_q;
  reg sel_s2_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
    end else begin
      sel_s1_q <= deep_fifo_select_n;
      sel_s2_q <= sel_s1_q;
    end
  end

  // ============================================================
  // mode decode
  wire fifo_en  = fifo_control_q[`FC_ENABLE];
  wire enhanced = enhanced_features_q[`EF_ENHANCED];
  wire dlab     = line_control_q[`LC_DLAB];
  wire enh_key  = enh_key_q;
  wire legacy_deep = ~enhanced & (fifo_control_q[`FC_DEEP] | ~sel_s2_q);
  reg  [7:0] depth_sel;
  always @* begin
    if (!fifo_en) begin
      depth_sel = `DEPTH_BYTE;
    end else if (enhanced) begin
      depth_sel = `DEPTH_DEEP;
    end else if (!sel_s2_q) begin
      depth_sel = `DEPTH_DEEP;
    end else if (fifo_control_q[`FC_DEEP]) begin
      depth_sel = `DEPTH_DEEP;
    end else begin
      depth_sel = `DEPTH_STD;
    end
  end
  assign fifo_depth = depth_sel;

  // legacy auto flow exists only while the deep mode came from the guarded bit or the pin; sleep also works with the fifo off
  assign auto_rts_cts = enhanced ? enhanced_features_q[`EF_AUTO_RTS] :
                        (fifo_en & legacy_deep & modem_ctl_q[`MC_AUTO_FLOW]);
  assign sleep_enable = ier_q[`IE_SLEEP] & (enhanced | ~fifo_en | legacy_deep);
  assign nine_bit_mode = enhanced & nine_bit_q[`NB_ENABLE];

  // ============================================================
  // fifos
  wire       wr_data  = host_wr & (host_addr == `OFF_DATA) & ~dlab;
  wire       rd_data  = host_rd & (host_addr == `OFF_DATA) & ~dlab;
  wire       fc_write = host_wr & (host_addr == `OFF_FIFO_CTL) & ~enh_key;
  wire       rx_flush = fc_write & host_wdata[`FC_RX_FLUSH];
  wire       tx_flush = fc_write & host_wdata[`FC_TX_FLUSH];
  wire [8:0] rx_head;
  wire       rx_ready;
  wire       rx_full;
  wire [7:0] rx_level;
  wire [7:0] tx_level;
  wire       tx_full;
  wire [8:0] tx_word = {nine_bit_mode & nine_bit_q[`NB_TX_BIT8], host_wdata};

  mode_fifo #(.WIDTH(9), .AW(7)) rx_fifo (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .depth_lim    (depth_sel),
    .flush        (rx_flush),
    .push         (rx_push),
    .push_data    (rx_data),
    .pop          (rd_data),
    .head_q       (rx_head),
    .head_valid_q (rx_ready),
    .full         (rx_full),
    .level_q      (rx_level)
  );

  mode_fifo #(.WIDTH(9), .AW(7)) tx_fifo (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .depth_lim    (depth_sel),
    .flush        (tx_flush),
    .push         (wr_data),
    .push_data    (tx_word),
    .pop          (tx_take),
    .head_q       (tx_data),
    .head_valid_q (tx_valid),
    .full         (tx_full),
    .level_q      (tx_level)
  );

  // ============================================================
  // thresholds: legacy table unless the threshold registers are selected
  wire       arb_trig = additional_control_q[`AC_TRIG];
  reg  [7:0] rx_trig_leg;
  always @* begin
    case (fifo_control_q[7:6])
      2'h0:    rx_trig_leg = 8'h01;
      2'h1:    rx_trig_leg = 8'h04;
      2'h2:    rx_trig_leg = 8'h08;
      default: rx_trig_leg = 8'h0e;
    endcase
  end
  wire [7:0] rx_trig  = arb_trig ? rx_interrupt_threshold_q : rx_trig_leg;
  wire [7:0] tx_trig  = arb_trig ? tx_threshold_q : 8'h01;
  wire [7:0] flow_hi  = arb_trig ? flow_high_threshold_q : rx_trig;
  wire [7:0] flow_lo  = arb_trig ? flow_low_threshold_q : 8'h00;
  assign rx_trigger_hit = fifo_en ? (rx_level >= rx_trig) : rx_ready;
  assign tx_trigger_hit = tx_level < tx_trig;
  assign remote_stop    = remote_stop_q;

  // hysteresis: stop the far transmitter at the high mark, release at the low mark
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      remote_stop_q <= 1'b0;
    end else if (rx_level >= flow_hi) begin
      remote_stop_q <= 1'b1;
    end else if (rx_level <= flow_lo) begin
      remote_stop_q <= 1'b0;
    end
  end

  // ============================================================
  // modem pins and clocks
  assign dtr_o  = ~modem_ctl_q[`MC_DTR];
  // dtr turns into an input when it carries the external transmit clock
  assign dtr_oe = ~(clock_select_q[`CK_TX_EXT] & clock_select_q[`CK_TX_DTR]);

  baud_clock_gen baud (
    .sys_clk            (sys_clk),
    .rstn               (rstn),
    .prescaler_ratio    (prescaler_ratio_q),
    .divisor            (divisor_q),
    .sample_clock_ratio (sample_clock_ratio_q),
    .clock_select       (clock_select_q),
    .ring_indicator_n   (ring_indicator_n),
    .dsr_n              (dsr_n),
    .dtr_i              (dtr_i),
    .rx_sample_tick     (rx_sample_tick),
    .tx_bit_tick        (tx_bit_tick),
    .sample_ratio       (sample_ratio)
  );

  // ============================================================
  // register writes
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fifo_control_q           <= `RST_BYTE;
      line_control_q           <= `RST_BYTE;
      enhanced_features_q      <= `RST_BYTE;
      ier_q                    <= `RST_BYTE;
      modem_ctl_q              <= `RST_BYTE;
      icr_index_q              <= `RST_BYTE;
      divisor_q                <= `RST_DIVISOR;
      additional_control_q     <= `RST_BYTE;
      prescaler_ratio_q        <= `RST_PRESCALER;
      clock_select_q           <= `RST_BYTE;
      sample_clock_ratio_q     <= `RST_SAMPLE;
      rx_interrupt_threshold_q <= `RST_BYTE;
      tx_threshold_q           <= `RST_BYTE;
      flow_low_threshold_q     <= `RST_BYTE;
      flow_high_threshold_q    <= `RST_BYTE;
      nine_bit_q               <= `RST_BYTE;
      enh_key_q                <= 1'b0;
    end else if (host_wr) begin
      case (host_addr)
        `OFF_DATA: if (dlab) divisor_q[7:0] <= host_wdata;
        `OFF_IER: begin
          if (dlab) begin
            divisor_q[15:8] <= host_wdata;
          end else begin
            ier_q <= host_wdata;
          end
        end
        `OFF_FIFO_CTL: begin
          if (enh_key) begin
            enhanced_features_q <= host_wdata;
          end else begin
            // flush bits act as strobes; the deep bit keeps its value unless the guard is open
            fifo_control_q <= {host_wdata[7:6],
                               dlab ? host_wdata[`FC_DEEP] : fifo_control_q[`FC_DEEP],
                               host_wdata[4:3], 2'b00, host_wdata[`FC_ENABLE]};
          end
        end
        `OFF_LINE_CTL: begin
          // writing the key opens the enhanced set but keeps the frame format bits
          line_control_q <= (host_wdata == `ENH_KEY) ? {1'b1, line_control_q[6:0]} : host_wdata;
          enh_key_q <= (host_wdata == `ENH_KEY);
        end
        `OFF_MODEM_CTL: modem_ctl_q <= host_wdata;
        `OFF_ICR_DATA: begin
          case (icr_index_q)
            `IDX_ADD_CTL:   additional_control_q     <= host_wdata;
            `IDX_PRESCALER: prescaler_ratio_q        <= host_wdata;
            `IDX_CLOCK_SEL: clock_select_q           <= host_wdata;
            `IDX_SAMPLE:    sample_clock_ratio_q     <= host_wdata;
            `IDX_RX_TRIG:   rx_interrupt_threshold_q <= host_wdata;
            `IDX_TX_TRIG:   tx_threshold_q           <= host_wdata;
            `IDX_FLOW_LOW:  flow_low_threshold_q     <= host_wdata;
            `IDX_FLOW_HIGH: flow_high_threshold_q    <= host_wdata;
            `IDX_NINE_BIT:  nine_bit_q               <= host_wdata;
            default:        nine_bit_q               <= nine_bit_q;
          endcase
        end
        `OFF_ICR_INDEX: icr_index_q <= host_wdata;
        default: icr_index_q <= icr_index_q;
      endcase
    end
  end

  // ============================================================
  // reads
  reg [7:0] icr_rd;
  always @* begin
    case (icr_index_q)
      `IDX_ADD_CTL:   icr_rd = additional_control_q;
      `IDX_PRESCALER: icr_rd = prescaler_ratio_q;
      `IDX_CLOCK_SEL: icr_rd = clock_select_q;
      `IDX_SAMPLE:    icr_rd = sample_clock_ratio_q;
      `IDX_RX_TRIG:   icr_rd = rx_interrupt_threshold_q;
      `IDX_TX_TRIG:   icr_rd = tx_threshold_q;
      `IDX_FLOW_LOW:  icr_rd = flow_low_threshold_q;
      `IDX_FLOW_HIGH: icr_rd = flow_high_threshold_q;
      `IDX_NINE_BIT:  icr_rd = nine_bit_q;
      default:        icr_rd = 8'h00;
    endcase
  end

  wire       stat_map  = additional_control_q[`AC_STAT];
  wire [7:0] line_stat = {1'b0, ~tx_valid & (tx_level == 8'h00), tx_level == 8'h00, 2'b00,
                          nine_bit_mode & rx_head[8], overrun_q, rx_ready};
  wire       lsr_read  = host_rd & (host_addr == `OFF_ICR_DATA) & ~additional_control_q[`AC_ICR];
  reg  [7:0] rd_mux;
  always @* begin
    case (host_addr)
      `OFF_DATA:      rd_mux = dlab ? divisor_q[7:0] : rx_head[7:0];
      `OFF_IER:       rd_mux = dlab ? divisor_q[15:8] :
                               stat_map ? {6'h00, remote_stop_q, remote_xoff} : ier_q;
      `OFF_FIFO_CTL:  rd_mux = enh_key ? enhanced_features_q : {fifo_en, fifo_en, 6'h01};
      `OFF_LINE_CTL:  rd_mux = stat_map ? rx_level : line_control_q;
      `OFF_MODEM_CTL: rd_mux = stat_map ? tx_level : modem_ctl_q;
      `OFF_ICR_DATA:  rd_mux = additional_control_q[`AC_ICR] ? icr_rd : line_stat;
      `OFF_ICR_INDEX: rd_mux = icr_index_q;
      default:        rd_mux = 8'h00;
    endcase
  end

  // overrun is sticky; a drop in the same cycle as the status read stays set
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= 8'h00;
      overrun_q  <= 1'b0;
    end else begin
      if (host_rd) begin
        host_rdata <= rd_mux;
      end
      if (rx_push & rx_full) begin
        overrun_q <= 1'b1;
      end else if (lsr_read) begin
        overrun_q <= 1'b0;
      end
    end
  end
endmodule // uart_mode_ctrl

/* testbench/uart_mode_props.sv */
// concurrent checks on the channel mode controller ports
`timescale 1ns/1ps
module uart_mode_props (
  input wire       sys_clk,
  input wire       rstn,
  input wire [2:0] host_addr,
  input wire       host_wr,
  input wire       host_rd,
  input wire [7:0] host_rdata,
  input wire       deep_fifo_select_n,
  input wire       tx_valid,
  input wire       tx_take,
  input wire [7:0] fifo_depth,
  input wire       auto_rts_cts,
  input wire       sleep_enable,
  input wire       nine_bit_mode,
  input wire       tx_bit_tick,
  input wire [4:0] sample_ratio
);
  // ============================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_reset_byte: assert property ($rose(rstn) |-> fifo_depth == 8'h01)
    else $error("depth not one after reset");
  a_depth_legal: assert property (fifo_depth inside {8'h01, 8'h10, 8'h80})
    else $error("illegal fifo depth");
  // pin passes two flops, so it must be quiet over three samples
  a_depth_hold: assert property (!(host_wr && host_addr == 3'h2) && $stable(deep_fifo_select_n)
    && $past(deep_fifo_select_n) == $past(deep_fifo_select_n, 2) |=> $stable(fifo_depth))
    else $error("depth moved without cause");
  a_legacy_gate: assert property (fifo_depth == 8'h10 |-> !auto_rts_cts && !sleep_enable)
    else $error("deep features on in 16 mode");
  a_enh_deep: assert property (nine_bit_mode && fifo_depth != 8'h01 |-> fifo_depth == 8'h80)
    else $error("enhanced fifo not 128");
  a_ratio_range: assert property (sample_ratio inside {[5'h04:5'h10]})
    else $error("sample ratio out of range");
  a_tick_gap: assert property (tx_bit_tick |=> !tx_bit_tick [*3])
    else $error("bit ticks too close");
  a_rdata_hold: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data moved without read");
  a_take_drop: assert property (tx_take && tx_valid |=> !tx_valid)
    else $error("tx head kept after take");
  c_deep: cover property (fifo_depth == 8'h80);
  c_std: cover property (fifo_depth == 8'h10);
  c_take: cover property (tx_take && tx_valid);
endmodule // uart_mode_props

bind uart_mode_ctrl uart_mode_props u_props (
  .sys_clk, .rstn, .host_addr, .host_wr, .host_rd, .host_rdata, .deep_fifo_select_n, .tx_valid,
  .tx_take, .fifo_depth, .auto_rts_cts, .sleep_enable, .nine_bit_mode, .tx_bit_tick, .sample_ratio
);

/* testbench/serial_far_end.sv */
// far side model: transmit word consumer with stall, receive word source
`timescale 1ns/1ps
module serial_far_end (
  input  wire       sys_clk,
  input  wire       stall,
  input  wire [8:0] tx_data,
  input  wire       tx_valid,
  output reg        tx_take,
  output reg  [8:0] rx_data,
  output reg        rx_push,
  output reg  [8:0] last_word,
  output reg  [7:0] taken
);
  // ============================================================
  // consumer: one pulse per word, then waits for the head again
  initial begin
    tx_take = 1'b0;
    rx_push = 1'b0;
    rx_data = 9'h000;
    last_word = 9'h000;
    taken = 8'h00;
  end
  always @(negedge sys_clk) tx_take <= tx_valid && !stall && !tx_take;
  always @(posedge sys_clk) begin
    if (tx_take && tx_valid) begin
      last_word <= tx_data;
      taken <= taken + 8'h01;
    end
  end
  // released line shows the inverse so a late sample cannot pass
  task push(input [8:0] w);
    begin
      @(negedge sys_clk);
      rx_data = w;
      rx_push = 1'b1;
      @(negedge sys_clk);
      rx_push = 1'b0;
      rx_data = ~w;
    end
  endtask
endmodule // serial_far_end

/* testbench/uart_mode_ctrl_tb.sv */
// self-checking bench for the channel mode controller
`timescale 1ns/1ps
`include "uart_mode_defs.vh"
module uart_mode_ctrl_tb;
  reg        sys_clk = 1'b0;
  reg        rstn = 1'b0;
  reg  [2:0] host_addr = 3'h0;
  reg  [7:0] host_wdata = 8'h00;
  reg        host_wr = 1'b0;
  reg        host_rd = 1'b0;
  reg        pin_n = 1'b1;
  reg        dsr_n = 1'b1;
  reg        xoff = 1'b0;
  reg        stall = 1'b1;
  integer    error_cnt = 0;
  integer    checks_done = 0;
  integer    i;
  wire [7:0] host_rdata, fifo_depth, taken;
  wire [8:0] tx_data, rx_data, last_word;
  wire [4:0] sample_ratio;
  wire       tx_valid, tx_take, rx_push, tx_bit_tick, dtr_o, dtr_oe;
  // ============================================================
  // clock, design and far side
  always #12.5 sys_clk = ~sys_clk;
  uart_mode_ctrl u_dut (
    .sys_clk, .rstn, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata,
    .deep_fifo_select_n(pin_n), .ring_indicator_n(1'b1), .dsr_n, .dtr_i(dtr_oe ? dtr_o : 1'b1),
    .dtr_o, .dtr_oe, .tx_data, .tx_valid, .tx_take, .rx_data, .rx_push, .remote_xoff(xoff),
    .fifo_depth, .rx_trigger_hit(), .tx_trigger_hit(), .remote_stop(), .auto_rts_cts(),
    .sleep_enable(), .nine_bit_mode(), .tx_bit_tick, .rx_sample_tick(), .sample_ratio
  );
  serial_far_end u_far (
    .sys_clk, .stall, .tx_data, .tx_valid, .tx_take, .rx_data, .rx_push, .last_word, .taken
  );
  task chk(input string nm, input [8:0] exp, input [8:0] seen);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one access per call; the idle cycle between calls keeps strobes single
  task acc(input w, input [2:0] a, input [7:0] d);
    begin
      @(negedge sys_clk);
      host_addr = a;
      host_wdata = d;
      host_wr = w;
      host_rd = !w;
      @(negedge sys_clk);
      host_wr = 1'b0;
      host_rd = 1'b0;
      if (!w) chk("host_rdata", {1'b0, d}, {1'b0, host_rdata});
    end
  endtask
  task iw(input [7:0] x, input [7:0] d);
    begin
      acc(1'b1, 3'h7, x);
      acc(1'b1, 3'h5, d);
    end
  endtask
  task dep(input p, input [7:0] exp);
    begin
      pin_n = p;
      repeat (4) @(negedge sys_clk);
      chk("fifo_depth", {1'b0, exp}, {1'b0, fifo_depth});
    end
  endtask
  // first two intervals are dropped: counters may hold old settings
  task gap(input [8:0] exp);
    integer n, k;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        n = 0;
        @(negedge sys_clk);
        while (tx_bit_tick !== 1'b1 && n < 400) begin
          @(negedge sys_clk);
          n = n + 1;
        end
      end
      chk("tx_bit_tick period", exp, n[8:0] + 9'h001);
      if (n >= 400) results;
    end
  endtask
  task t_clocks;
    begin
      chk("fifo_depth", {1'b0, `DEPTH_BYTE}, {1'b0, fifo_depth});
      chk("sample_ratio", 9'h010, {4'h0, sample_ratio});
      gap(9'h040);
      iw(8'h00, 8'hc0);
      acc(1'b1, 3'h7, 8'h01);
      acc(1'b0, 3'h5, `RST_PRESCALER);
      acc(1'b1, 3'h7, 8'h03);
      acc(1'b0, 3'h5, `RST_SAMPLE);
      for (i = 0; i < 16; i = i + 1) begin
        iw(8'h03, i[7:0]);
        chk("sample_ratio", (i < 4) ? 9'h010 : i[8:0], {4'h0, sample_ratio});
      end
      iw(8'h01, 8'h08);
      iw(8'h03, 8'h0d);
      gap(9'h00d);
      iw(8'h01, 8'h0c);
      iw(8'h03, 8'h04);
      gap(9'h006);
    end
  endtask
  task t_modes;
    begin
      dep(1'b0, `DEPTH_BYTE);
      acc(1'b1, 3'h3, `ENH_KEY);
      acc(1'b1, 3'h2, 8'h10);
      acc(1'b1, 3'h3, 8'h03);
      dep(1'b0, `DEPTH_BYTE);
      acc(1'b1, 3'h2, 8'h01);
      dep(1'b1, `DEPTH_DEEP);
      acc(1'b1, 3'h3, `ENH_KEY);
      acc(1'b1, 3'h2, 8'h00);
      acc(1'b1, 3'h3, 8'h03);
      dep(1'b1, `DEPTH_STD);
      dep(1'b0, `DEPTH_DEEP);
      acc(1'b1, 3'h2, 8'h21);
      dep(1'b1, `DEPTH_STD);
      acc(1'b1, 3'h3, 8'h80);
      acc(1'b1, 3'h2, 8'h21);
      acc(1'b1, 3'h3, 8'h03);
      dep(1'b1, `DEPTH_DEEP);
      acc(1'b1, 3'h2, 8'h01);
      dep(1'b1, `DEPTH_DEEP);
      acc(1'b1, 3'h2, 8'h00);
      dep(1'b0, `DEPTH_BYTE);
    end
  endtask
  task t_levels;
    begin
      acc(1'b1, 3'h2, 8'h01);
      repeat (3) acc(1'b1, 3'h0, 8'h41);
      acc(1'b0, 3'h4, 8'h03);
      xoff = 1'b1;
      repeat (3) @(negedge sys_clk);
      acc(1'b0, 3'h1, 8'h01);
      u_far.push(9'h055);
      u_far.push(9'h0aa);
      acc(1'b0, 3'h3, 8'h02);
      stall = 1'b0;
      repeat (12) @(negedge sys_clk);
      chk("words taken", 9'h003, {1'b0, taken});
      chk("last word", 9'h041, last_word);
    end
  endtask
  task t_select;
    begin
      iw(8'h02, 8'h31);
      chk("dtr_oe", 9'h000, {8'h00, dtr_oe});
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    t_clocks;
    t_modes;
    t_levels;
    t_select;
    results;
  end
endmodule // uart_mode_ctrl_tb
